// [sgh_motor.sv]
// motor model: encoder counts, index mark and home sensor that follow the homing command
module sgh_motor (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // synchronous reset
  input wire logic signed [15:0] vel_in, // homing speed command, rpm
  input wire logic signed [15:0] load_spd_in, // extra speed set by the bench, rpm
  output logic signed [15:0] speed_out, // measured speed, rpm
  output logic step_out, // one count pulse
  output logic dir_out, // 1 forward
  output logic index_out, // index mark level
  output logic sensor_out // home sensor level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] pos_ff;
  logic [1:0] div_ff;
  // one count every four cycles while a speed is commanded; dir is valid with the step
  always_ff @(posedge clk_in)
  begin
    div_ff <= rst_in ? 2'h0 : div_ff + 2'h1;
    step_out <= !rst_in && vel_in != 16'sh0 && div_ff == 2'h3;
    dir_out <= vel_in > 16'sh0;
    if (rst_in)
      pos_ff <= 16'sh0;
    else if (step_out)
      pos_ff <= dir_out ? pos_ff + 16'sh1 : pos_ff - 16'sh1;
  end
  // sensor covers the forward region, index every sixteen counts
  assign speed_out = vel_in + load_spd_in;
  assign index_out = pos_ff[3:0] == 4'h0;
  assign sensor_out = pos_ff >= 16'sh28;
endmodule

// [sgh_pkg.sv]
// constants, register map and state encodings of the servo gear/brake/homing block
package sgh_pkg;
  // clock rate and the millisecond tick derived from it
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  // register indices; the byte address is four times the index
  localparam logic [8:0] IX_BASE = 9'h120;
  localparam logic [8:0] IX_ZSPD = 9'h126;
  localparam logic [8:0] IX_VFS = 9'h128;
  localparam logic [8:0] IX_TFS = 9'h129;
  localparam logic [8:0] IX_BON = 9'h12a;
  localparam logic [8:0] IX_BOFF = 9'h12b;
  localparam logic [8:0] IX_GNUM = 9'h12c;
  localparam logic [8:0] IX_GDEN = 9'h12d;
  localparam logic [8:0] IX_PSCL = 9'h12e;
  localparam logic [8:0] IX_HSET = 9'h12f;
  localparam logic [8:0] IX_HFAST = 9'h130;
  localparam logic [8:0] IX_HCREEP = 9'h131;
  localparam logic [8:0] IX_HREV = 9'h132;
  localparam logic [8:0] IX_HCNT = 9'h133;
  localparam logic [8:0] IX_ALT1 = 9'h13c;
  localparam logic [8:0] IX_CTRL = 9'h13f;
  localparam logic [8:0] IX_STAT = 9'h140;
  localparam logic [8:0] IX_PFBL = 9'h141;
  localparam logic [8:0] IX_PFBH = 9'h142;
  // reset values
  localparam logic [15:0] RV_ZSPD = 16'h000a;
  localparam logic [15:0] RV_VFS = 16'h0bb8;
  localparam logic [15:0] RV_TFS = 16'h0064;
  localparam logic [15:0] RV_BDLY = 16'h0014;
  localparam logic [15:0] RV_GEAR = 16'h0001;
  localparam logic [15:0] RV_PSCL = 16'h0001;
  localparam logic [15:0] RV_HFAST = 16'h03e8;
  localparam logic [15:0] RV_HCREEP = 16'h0032;
  // scaling figures
  localparam int FULL_MV = 10000;
  localparam int SEL_SPLIT = 10000;
  localparam int SF_MAX = 125;
  localparam int PPR_MIN = 20;
  localparam int PPR_MAX = 2500;
  localparam int PPR_STEP = 20;
  localparam int LINES = 2500;
  localparam int CNT_PER_REV = 10000;
  // control and status fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GSEL_LSB = 2;
  localparam int ST_BRK = 0;
  localparam int ST_HACT = 1;
  localparam int ST_HDONE = 2;
  // control modes
  localparam logic [1:0] MODE_POS = 2'h0;
  localparam logic [1:0] MODE_VEL = 2'h1;
  localparam logic [1:0] MODE_TRQ = 2'h2;
  // homing setup digit codes
  localparam logic [3:0] SNS_FLIM = 4'h0;
  localparam logic [3:0] SNS_RLIM = 4'h1;
  localparam logic [3:0] SNS_FHOME = 4'h2;
  localparam logic [3:0] SNS_INDEX = 4'h4;
  localparam logic [3:0] IDX_REV = 4'h0;
  localparam logic [3:0] IDX_FWD = 4'h1;
  localparam logic [3:0] IDX_STAY = 4'h2;
  localparam logic [3:0] TRG_OFF = 4'h0;
  localparam logic [3:0] TRG_PWR = 4'h1;
  localparam logic [3:0] TRG_DI = 4'h2;
  localparam logic [3:0] STP_RET = 4'h0;
  typedef enum logic [1:0] {
    BRK_HOLD = 2'b00,
    BRK_ON = 2'b01,
    BRK_REL = 2'b10,
    BRK_OFF = 2'b11
  } sgh_brk_t;
  typedef enum logic [2:0] {
    HM_IDLE = 3'b000,
    HM_FAST = 3'b001,
    HM_OFF = 3'b010,
    HM_INDEX = 3'b011,
    HM_DONE = 3'b100
  } sgh_home_t;
endpackage

// [sgh_top.sv]
// servo motion support: analog scaling, brake sequencing, gearing, encoder output, homing
// What this block does
// - in position and torque modes velocity limit is input volts times full scale over 10 V
// - in velocity mode input maps linearly, both signs, onto the velocity command
// - in position and velocity modes torque limit is volts times torque full scale over 10 V
// - in torque mode 10 V commands the full scale torque percentage, both signs
// - after enable wait the on delay in ms before releasing the brake
// - after disable wait the off delay in ms before engaging the brake
// - motor below zero speed threshold at servo off engages the brake at once
// - motor above threshold at servo off engages brake when off delay expires
// - position command is input pulses times numerator over denominator
// - alternative numerators may replace the first, sharing the denominator
// - scaling applies to quadrature outputs only, index output passes unchanged
// - selector zero gives 2500 over scale factor pulses per rev, factor 1 to 125
// - selector one gives the set pulse count per rev, 20 to 2500, steps of 20
// - sensor digit picks forward/reverse limit, forward/reverse home sensor or index
// - index digit picks reverse to index, forward to index, or stop at sensor
// - trigger digit picks disabled, start at power-up, or start from digital input
// - stop digit picks return to home or stop in the forward direction
// - fast speed until sensor, creep back off sensor, stop at next index pulse
// - the secondary homing phase runs at the programmed creep speed
// - limit inputs used as home sensor regain overtravel protection after homing
// - at homing end position loads offset revs times 10000 plus offset counts
// - zero speed threshold for brake decisions is a programmable rpm level
//
// Added by the designer: the Wishbone interface to the registers.
module sgh_top
  import sgh_pkg::*;
#(
  parameter int MS_CYCLES = sgh_pkg::MS_CYC
) (
  input wire logic sys_clk_in, // 25 MHz clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic wb_cyc_in, // bus cycle
  input wire logic wb_stb_in, // bus strobe
  input wire logic wb_we_in, // write enable
  input wire logic [10:0] wb_adr_in, // byte address
  input wire logic [3:0] wb_sel_in, // byte lanes
  input wire logic [31:0] wb_dat_in, // write data
  output logic [31:0] wb_dat_out, // read data
  output logic wb_ack_out, // acknowledge
  input wire logic signed [15:0] ana_vel_in, // velocity analog input, mV
  input wire logic signed [15:0] ana_trq_in, // torque analog input, mV
  output logic signed [15:0] vel_cmd_out, // velocity command, rpm
  output logic signed [15:0] vel_lim_out, // velocity limit, rpm
  output logic signed [15:0] trq_cmd_out, // torque command, percent
  output logic signed [15:0] trq_lim_out, // torque limit, percent
  input wire logic drive_en_in, // servo on
  input wire logic signed [15:0] motor_speed_in, // measured speed, rpm
  output logic brake_release_out, // high releases the brake
  input wire logic cmd_pulse_in, // command pulse
  input wire logic cmd_dir_in, // command direction, 1 forward
  output logic signed [31:0] pos_cmd_out, // geared position command
  input wire logic enc_step_in, // motor encoder count
  input wire logic enc_dir_in, // encoder direction, 1 forward
  input wire logic index_in, // motor index pulse
  output logic quad_out_a, // emulated channel a
  output logic quad_out_a_n, // complement of a
  output logic quad_out_b, // emulated channel b
  output logic quad_out_b_n, // complement of b
  output logic index_out, // index output
  output logic index_out_n, // complement of index
  input wire logic fwd_limit_in, // forward overtravel switch
  input wire logic rev_limit_in, // reverse overtravel switch
  input wire logic home_sensor_in, // dedicated home sensor
  input wire logic digital_input, // homing start input
  output logic signed [15:0] home_vel_out, // homing speed command, rpm
  output logic home_active_out, // homing in progress
  output logic home_done_out, // homing completed
  output logic home_return_out, // move back to home requested
  output logic ot_protect_out, // overtravel protection active
  output logic signed [31:0] pos_fb_out // actual position, counts
);
  typedef struct packed {
    logic [31:0][15:0] regs;
    logic ack;
    logic [31:0] rdat;
    sgh_brk_t brk;
    logic [15:0] pre;
    logic [15:0] msc;
    logic signed [31:0] grem;
    logic signed [31:0] pcmd;
    logic signed [15:0] eacc;
    logic [1:0] quad;
    logic idx;
    logic signed [31:0] pfb;
    sgh_home_t hm;
    logic hdone;
    logic armed;
    logic di_d;
    logic signed [15:0] hvel;
    logic signed [15:0] vc;
    logic signed [15:0] vl;
    logic signed [15:0] tc;
    logic signed [15:0] tl;
  } sgh_st_t;
  sgh_st_t st, nxt_st;
  logic [8:0] wb_ix;
  logic wb_req;
  logic [15:0] vfs, tfs, bon, boff, zspd, den_eff, num_sel, pscl, hset;
  logic [1:0] mode;
  logic [1:0] gsel;
  logic signed [31:0] vprod, tprod, hoff;
  logic signed [15:0] vs, ts, spd_abs;
  logic slow;
  logic bsel;
  logic [15:0] a_fld, sf, ppr, einc, emod;
  logic estep_f, estep_r;
  logic [3:0] scode, icode, tcode, pcode;
  logic hit, fast_fwd, creep_fwd, hstart;
  // decimal digit of the homing setup, k = 0 is the least significant
  function automatic logic [3:0] digit(input logic [15:0] v, input int k);
    logic [15:0] q;
    q = v;
    for (int i = 0; i < k; i++)
      q = q / 16'd10;
    return 4'(q % 16'd10);
  endfunction
  // writable register indices
  function automatic logic is_rw(input logic [8:0] ix);
    return ix == IX_ZSPD || (ix >= IX_VFS && ix <= IX_HCNT) || (ix >= IX_ALT1 && ix <= IX_CTRL);
  endfunction
  // reset image of the register file
  function automatic logic [31:0][15:0] reg_rst();
    logic [31:0][15:0] r;
    r = '0;
    r[IX_ZSPD[4:0]] = RV_ZSPD;
    r[IX_VFS[4:0]] = RV_VFS;
    r[IX_TFS[4:0]] = RV_TFS;
    r[IX_BON[4:0]] = RV_BDLY;
    r[IX_BOFF[4:0]] = RV_BDLY;
    r[IX_GNUM[4:0]] = RV_GEAR;
    r[IX_GDEN[4:0]] = RV_GEAR;
    r[IX_PSCL[4:0]] = RV_PSCL;
    r[IX_HFAST[4:0]] = RV_HFAST;
    r[IX_HCREEP[4:0]] = RV_HCREEP;
    return r;
  endfunction
  // register fields and bus decode
  assign wb_ix = wb_adr_in[10:2];
  assign wb_req = wb_cyc_in && wb_stb_in && !st.ack;
  assign zspd = st.regs[IX_ZSPD[4:0]];
  assign vfs = st.regs[IX_VFS[4:0]];
  assign tfs = st.regs[IX_TFS[4:0]];
  assign bon = st.regs[IX_BON[4:0]];
  assign boff = st.regs[IX_BOFF[4:0]];
  assign pscl = st.regs[IX_PSCL[4:0]];
  assign hset = st.regs[IX_HSET[4:0]];
  assign mode = st.regs[IX_CTRL[4:0]][CTRL_MODE_LSB +: 2];
  assign gsel = st.regs[IX_CTRL[4:0]][CTRL_GSEL_LSB +: 2];
  assign num_sel = (gsel == 2'h0) ? st.regs[IX_GNUM[4:0]] :
                   st.regs[5'(IX_ALT1[4:0] + {3'h0, gsel} - 5'h1)];
  assign den_eff = (st.regs[IX_GDEN[4:0]] == 16'h0) ? 16'h1 : st.regs[IX_GDEN[4:0]];
  // analog scaling, full scale reached at 10 V; widened first so the product cannot wrap
  assign vprod = 32'(ana_vel_in) * $signed({16'h0, vfs});
  assign tprod = 32'(ana_trq_in) * $signed({16'h0, tfs});
  assign vs = 16'(vprod / FULL_MV);
  assign ts = 16'(tprod / FULL_MV);
  // brake speed test
  assign spd_abs = motor_speed_in[15] ? -motor_speed_in : motor_speed_in;
  assign slow = spd_abs < $signed({1'b0, zspd[14:0]});
  // encoder output scaling decode
  assign bsel = pscl >= 16'(SEL_SPLIT);
  assign a_fld = bsel ? pscl - 16'(SEL_SPLIT) : pscl;
  assign sf = (a_fld == 16'h0) ? 16'h1 : (a_fld > 16'(SF_MAX)) ? 16'(SF_MAX) : a_fld;
  assign ppr = (a_fld < 16'(PPR_MIN)) ? 16'(PPR_MIN) :
               (a_fld > 16'(PPR_MAX)) ? 16'(PPR_MAX) :
               a_fld - (a_fld % 16'(PPR_STEP));
  assign einc = bsel ? ppr : 16'h1;
  assign emod = bsel ? 16'(LINES) : sf;
  assign estep_f = st.eacc >= $signed(emod);
  assign estep_r = st.eacc <= -$signed(emod);
  // homing setup digits and sensor selection
  assign scode = digit(hset, 0);
  assign icode = digit(hset, 1);
  assign tcode = digit(hset, 2);
  assign pcode = digit(hset, 3);
  always_comb
  begin
    unique case (scode)
      SNS_FLIM: hit = fwd_limit_in;
      SNS_RLIM: hit = rev_limit_in;
      SNS_INDEX: hit = index_in;
      default: hit = home_sensor_in;
    endcase
  end
  assign fast_fwd = (scode == SNS_INDEX) ? (icode == IDX_FWD) : !scode[0];
  assign creep_fwd = (icode == IDX_FWD) ? 1'b1 : !fast_fwd;
  assign hstart = (st.hm == HM_IDLE) && ((tcode == TRG_PWR && st.armed) ||
                  (tcode == TRG_DI && digital_input && !st.di_d));
  assign hoff = 32'($signed(st.regs[IX_HREV[4:0]]) * CNT_PER_REV) +
                32'($signed(st.regs[IX_HCNT[4:0]]));
  // next state of the whole block
  always_comb
  begin
    nxt_st = st;
    // wishbone slave, one wait state
    nxt_st.ack = wb_req;
    if (wb_req)
    begin
      nxt_st.rdat = '0;
      if (wb_ix >= IX_BASE && wb_ix <= IX_CTRL)
        nxt_st.rdat = {16'h0, st.regs[wb_ix[4:0]]};
      else if (wb_ix == IX_STAT)
        nxt_st.rdat = {29'h0, st.hdone, st.hm != HM_IDLE, brake_release_out};
      else if (wb_ix == IX_PFBL)
        nxt_st.rdat = {16'h0, st.pfb[15:0]};
      else if (wb_ix == IX_PFBH)
        nxt_st.rdat = {16'h0, st.pfb[31:16]};
      if (wb_we_in && is_rw(wb_ix))
      begin
        if (wb_sel_in[0])
          nxt_st.regs[wb_ix[4:0]][7:0] = wb_dat_in[7:0];
        if (wb_sel_in[1])
          nxt_st.regs[wb_ix[4:0]][15:8] = wb_dat_in[15:8];
      end
    end
    // analog commands and limits per control mode
    nxt_st.vc = (mode == MODE_VEL) ? vs : 16'sh0;
    nxt_st.vl = (mode != MODE_VEL) ? vs : 16'sh0;
    nxt_st.tc = (mode == MODE_TRQ) ? ts : 16'sh0;
    nxt_st.tl = (mode != MODE_TRQ) ? ts : 16'sh0;
    // millisecond timer for the brake delays
    if (st.pre == 16'(MS_CYCLES - 1))
    begin
      nxt_st.pre = '0;
      nxt_st.msc = st.msc + 16'h1;
    end
    else
      nxt_st.pre = st.pre + 16'h1;
    unique case (st.brk)
      BRK_HOLD:
        if (drive_en_in)
        begin
          nxt_st.brk = BRK_ON;
          nxt_st.pre = '0;
          nxt_st.msc = '0;
        end
      BRK_ON:
        if (!drive_en_in)
          nxt_st.brk = BRK_HOLD;
        else if (st.msc >= bon)
          nxt_st.brk = BRK_REL;
      BRK_REL:
        if (!drive_en_in)
        begin
          nxt_st.pre = '0;
          nxt_st.msc = '0;
          if (slow || boff == 16'h0)
            nxt_st.brk = BRK_HOLD;
          else
            nxt_st.brk = BRK_OFF;
        end
      BRK_OFF:
        if (st.msc >= boff)
          nxt_st.brk = BRK_HOLD;
        else if (drive_en_in)
          nxt_st.brk = BRK_REL;
    endcase
    // electronic gear: remainder takes num per pulse, gives den per output count
    nxt_st.grem = st.grem + (cmd_pulse_in ? (cmd_dir_in ? $signed({16'h0, num_sel}) :
                  -$signed({16'h0, num_sel})) : 32'sh0);
    if (st.grem >= $signed({16'h0, den_eff}))
    begin
      nxt_st.grem = nxt_st.grem - $signed({16'h0, den_eff});
      nxt_st.pcmd = st.pcmd + 32'sh1;
    end
    else if (st.grem <= -$signed({16'h0, den_eff}))
    begin
      nxt_st.grem = nxt_st.grem + $signed({16'h0, den_eff});
      nxt_st.pcmd = st.pcmd - 32'sh1;
    end
    // encoder emulation: one quadrature edge each time the accumulator wraps
    nxt_st.eacc = st.eacc + (enc_step_in ? (enc_dir_in ? $signed(einc) : -$signed(einc)) :
                  16'sh0);
    if (estep_f)
    begin
      nxt_st.eacc = nxt_st.eacc - $signed(emod);
      nxt_st.quad = st.quad + 2'h1;
    end
    else if (estep_r)
    begin
      nxt_st.eacc = nxt_st.eacc + $signed(emod);
      nxt_st.quad = st.quad - 2'h1;
    end
    nxt_st.idx = index_in;
    // actual position from the motor encoder
    if (enc_step_in)
      nxt_st.pfb = enc_dir_in ? st.pfb + 32'sh1 : st.pfb - 32'sh1;
    // homing sequencer
    nxt_st.di_d = digital_input;
    nxt_st.hvel = 16'sh0;
    unique case (st.hm)
      HM_IDLE:
        if (hstart)
        begin
          nxt_st.hm = HM_FAST;
          nxt_st.armed = 1'b0;
          nxt_st.hdone = 1'b0;
        end
      HM_FAST:
      begin
        nxt_st.hvel = fast_fwd ? $signed(st.regs[IX_HFAST[4:0]]) :
                      -$signed(st.regs[IX_HFAST[4:0]]);
        if (hit)
          nxt_st.hm = (scode == SNS_INDEX || icode == IDX_STAY) ? HM_DONE : HM_OFF;
      end
      HM_OFF:
      begin
        nxt_st.hvel = creep_fwd ? $signed(st.regs[IX_HCREEP[4:0]]) :
                      -$signed(st.regs[IX_HCREEP[4:0]]);
        if (!hit)
          nxt_st.hm = HM_INDEX;
      end
      HM_INDEX:
      begin
        nxt_st.hvel = creep_fwd ? $signed(st.regs[IX_HCREEP[4:0]]) :
                      -$signed(st.regs[IX_HCREEP[4:0]]);
        if (index_in)
          nxt_st.hm = HM_DONE;
      end
      HM_DONE:
      begin
        nxt_st.pfb = hoff;
        nxt_st.hdone = 1'b1;
        nxt_st.hm = HM_IDLE;
      end
      default:
        nxt_st.hm = HM_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st <= '0; // idle brake and homing states are the all-zero codes
      st.regs <= reg_rst();
      st.armed <= 1'b1;
    end
    else
      st <= nxt_st;
  end
  // outputs
  assign wb_ack_out = st.ack;
  assign wb_dat_out = st.rdat;
  assign vel_cmd_out = st.vc;
  assign vel_lim_out = st.vl;
  assign trq_cmd_out = st.tc;
  assign trq_lim_out = st.tl;
  assign brake_release_out = (st.brk == BRK_REL) || (st.brk == BRK_OFF);
  assign pos_cmd_out = st.pcmd;
  assign quad_out_a = st.quad[1];
  assign quad_out_b = st.quad[1] ^ st.quad[0];
  assign quad_out_a_n = !quad_out_a;
  assign quad_out_b_n = !quad_out_b;
  assign index_out = st.idx;
  assign index_out_n = !st.idx;
  assign home_vel_out = st.hvel;
  assign home_active_out = st.hm != HM_IDLE;
  assign home_done_out = st.hdone;
  assign home_return_out = st.hdone && pcode == STP_RET;
  assign ot_protect_out = !(home_active_out && (scode == SNS_FLIM || scode == SNS_RLIM));
  assign pos_fb_out = st.pfb;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_off_slow;
    st.brk == BRK_REL && !drive_en_in && slow;
  endsequence
  sequence s_off_fast;
    st.brk == BRK_REL && !drive_en_in && !slow && boff != 16'h0;
  endsequence
  AST_BRK_WAIT: assert property (st.brk == BRK_ON |-> !brake_release_out)
    else $error("brake released before on delay");
  AST_BRK_REL: assert property (st.brk == BRK_ON && drive_en_in && st.msc >= bon
    |=> brake_release_out)
    else $error("brake not released at on delay");
  AST_BRK_SLOW: assert property (s_off_slow |=> !brake_release_out)
    else $error("slow servo off did not engage brake");
  AST_BRK_FAST: assert property (s_off_fast |=> brake_release_out ##0 st.msc == 16'h0)
    else $error("fast servo off engaged brake early");
  AST_BRK_EXP: assert property (st.brk == BRK_OFF && st.msc >= boff |=> !brake_release_out)
    else $error("brake not engaged at off delay");
  AST_GEAR: assert property (st.grem >= $signed({16'h0, den_eff})
    |=> st.pcmd == $past(st.pcmd) + 32'sh1)
    else $error("gear output count missing");
  AST_IDX: assert property (!$past(rst_in) |-> index_out == $past(index_in))
    else $error("index output altered");
  AST_QUAD: assert property (!$past(rst_in) && st.quad != $past(st.quad)
    |-> $past(estep_f) || $past(estep_r))
    else $error("quadrature step without wrap");
  AST_OT: assert property (st.hm == HM_IDLE |-> ot_protect_out)
    else $error("overtravel protection left off");
  AST_HOFF: assert property (st.hm == HM_DONE |=> st.pfb == $past(hoff) && home_done_out)
    else $error("home offset not loaded");
  AST_TRG0: assert property (st.hm == HM_IDLE && tcode == TRG_OFF |=> st.hm == HM_IDLE)
    else $error("homing started while disabled");
endmodule

// [tb_servo_gear_home_brake.sv]
// self-checking bench of the gear, brake, scaling and homing block
module tb_servo_gear_home_brake;
  timeunit 1ns;
  timeprecision 1ns;
  import sgh_pkg::*;
  localparam int MS = 4;
  logic sys_clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [10:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, q;
  logic signed [15:0] ana_vel_in, ana_trq_in, vel_cmd_out, vel_lim_out, trq_cmd_out;
  logic signed [15:0] trq_lim_out, motor_speed_in, home_vel_out, load_spd;
  logic drive_en_in, brake_release_out, cmd_pulse_in, cmd_dir_in, enc_step_in, enc_dir_in;
  logic index_in, quad_out_a, quad_out_a_n, quad_out_b, quad_out_b_n, index_out;
  logic index_out_n, fwd_limit_in, rev_limit_in, home_sensor_in, digital_input;
  logic home_active_out, home_done_out, home_return_out, ot_protect_out, idx_d, rst_d;
  logic [1:0] qab_d;
  logic signed [31:0] pos_cmd_out, pos_fb_out;
  int n_fail, comparisons, seed, cyc, i, m, vfs, tfs, n_es, n_qc;
  logic [8:0] rix [11] = '{IX_TFS, IX_BON, IX_BOFF, IX_GNUM, IX_GDEN, IX_PSCL, IX_HSET,
    IX_HFAST, IX_HCREEP, IX_HREV, IX_HCNT};
  logic [15:0] rvl [11] = '{16'h0064, 16'h0014, 16'h0014, 16'h0001, 16'h0001, 16'h0001,
    16'h0000, 16'h03e8, 16'h0032, 16'h0000, 16'h0000};
  sgh_top #(.MS_CYCLES(MS)) i_dut (.*);
  sgh_motor i_motor (.clk_in(sys_clk_in), .rst_in(rst_in), .vel_in(home_vel_out),
    .load_spd_in(load_spd), .speed_out(motor_speed_in), .step_out(enc_step_in),
    .dir_out(enc_dir_in), .index_out(index_in), .sensor_out(home_sensor_in));
  assign fwd_limit_in = home_sensor_in;
  // clock generation
  always #20 sys_clk_in = ~sys_clk_in;
  // expected scaled value, truncating toward zero
  function automatic int scl(input int mv, input int fs);
    return mv * fs / FULL_MV;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [8:0] ix, input logic [15:0] d);
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= {ix, 2'h0};
    wb_dat_in <= {16'h0000, d};
    @(posedge sys_clk_in);
    while (wb_ack_out !== 1'b1)
      @(posedge sys_clk_in);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic pulses(input int n, input logic dir);
    repeat (n)
    begin
      cmd_pulse_in <= 1'b1;
      cmd_dir_in <= dir;
      @(posedge sys_clk_in);
      cmd_pulse_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
    end
    repeat (4) @(posedge sys_clk_in);
  endtask
  task automatic home_start;
    digital_input <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    digital_input <= 1'b0;
  endtask
  task print_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // index passes one cycle late and unscaled; complements track; quad edges counted; hang guard
  always @(posedge sys_clk_in)
  begin
    idx_d <= index_in;
    rst_d <= rst_in;
    qab_d <= {quad_out_a, quad_out_b};
    n_es += enc_step_in;
    n_qc += ({quad_out_a, quad_out_b} != qab_d);
    cyc++;
    if (cyc > 20 && !rst_d)
    begin
      chk(index_out, idx_d);
      chk(index_out_n, !idx_d);
      chk(quad_out_a_n, !quad_out_a);
      chk(quad_out_b_n, !quad_out_b);
    end
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  initial
  begin
    {sys_clk_in, wb_cyc_in, wb_stb_in, wb_we_in, drive_en_in, cmd_pulse_in} = '0;
    {cmd_dir_in, rev_limit_in, digital_input} = '0;
    {wb_adr_in, wb_dat_in, ana_vel_in, ana_trq_in, load_spd} = '0;
    wb_sel_in = 4'hf;
    seed = 68;
    rst_in = 1'b1;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 11; i++)
    begin
      wb(1'b0, rix[i], 16'h0000);
      chk(q, {16'h0000, rvl[i]});
    end
    wb(1'b0, 9'h150, 16'h0000);
    chk(q, 32'h0);
    // analog scaling in every mode with random inputs and full scales
    for (i = 0; i < 6; i++)
    begin
      m = i % 3;
      vfs = {$random(seed)} % 10001;
      tfs = {$random(seed)} % 1001;
      wb(1'b1, IX_VFS, vfs[15:0]);
      wb(1'b1, IX_TFS, tfs[15:0]);
      wb(1'b1, IX_CTRL, m[15:0]);
      ana_vel_in <= 16'($random(seed) % 10001);
      ana_trq_in <= i == 0 ? -16'sd10000 : 16'($random(seed) % 10001);
      repeat (3) @(posedge sys_clk_in);
      chk(vel_cmd_out, m == 1 ? scl(ana_vel_in, vfs) : 0);
      chk(vel_lim_out, m != 1 ? scl(ana_vel_in, vfs) : 0);
      chk(trq_cmd_out, m == 2 ? scl(ana_trq_in, tfs) : 0);
      chk(trq_lim_out, m != 2 ? scl(ana_trq_in, tfs) : 0);
    end
    // gearing with first and alternative numerator
    wb(1'b1, IX_CTRL, 16'h0000);
    wb(1'b1, IX_GNUM, 16'h0003);
    wb(1'b1, IX_GDEN, 16'h0002);
    pulses(10, 1'b1);
    chk(pos_cmd_out, 32'd15);
    wb(1'b1, IX_ALT1, 16'h0004);
    wb(1'b1, IX_CTRL, 16'h0004);
    pulses(5, 1'b0);
    chk(pos_cmd_out, 32'd5);
    // brake on and off delays, motor fast at servo off
    wb(1'b1, IX_BON, 16'h0003);
    wb(1'b1, IX_BOFF, 16'h0005);
    drive_en_in <= 1'b1;
    repeat (3 * MS - 2) @(posedge sys_clk_in);
    chk(brake_release_out, 1'b0);
    repeat (6) @(posedge sys_clk_in);
    chk(brake_release_out, 1'b1);
    load_spd <= 16'sd100;
    drive_en_in <= 1'b0;
    repeat (5 * MS - 2) @(posedge sys_clk_in);
    chk(brake_release_out, 1'b1);
    repeat (6) @(posedge sys_clk_in);
    chk(brake_release_out, 1'b0);
    // slow motor at servo off engages at once, for two thresholds
    for (i = 0; i < 2; i++)
    begin
      wb(1'b1, IX_ZSPD, i ? 16'h0032 : 16'h000a);
      drive_en_in <= 1'b1;
      repeat (20) @(posedge sys_clk_in);
      chk(brake_release_out, 1'b1);
      load_spd <= i ? 16'sd30 : 16'sd5;
      drive_en_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      chk(brake_release_out, 1'b0);
    end
    load_spd <= 16'sh0;
    // homing disabled, then forward home sensor with return and offset
    wb(1'b1, IX_HSET, 16'h0002);
    home_start();
    chk(home_active_out, 1'b0);
    wb(1'b1, IX_HREV, 16'h0002);
    wb(1'b1, IX_HCNT, 16'hfff9);
    wb(1'b1, IX_HSET, 16'h00ca);
    n_es = 0;
    n_qc = 0;
    home_start();
    chk(home_vel_out, 32'd1000);
    while (home_sensor_in !== 1'b1)
      @(posedge sys_clk_in);
    repeat (4) @(posedge sys_clk_in);
    chk(home_vel_out, -32'sd50);
    while (home_done_out !== 1'b1)
      @(posedge sys_clk_in);
    chk(pos_fb_out, 32'd19993);
    chk(home_return_out, 1'b1);
    chk(n_qc, n_es);
    // forward limit as home sensor loses overtravel protection; output set to 2500 per rev
    wb(1'b1, IX_PSCL, 16'h30d4);
    wb(1'b1, IX_HSET, 16'h00c8);
    n_es = 0;
    n_qc = 0;
    home_start();
    chk(home_active_out, 1'b1);
    chk(ot_protect_out, 1'b0);
    while (home_active_out !== 1'b0)
      @(posedge sys_clk_in);
    chk(ot_protect_out, 1'b1);
    chk(n_qc, n_es);
    // mid-run reset, then power-up trigger homing on the index mark with forward stop
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    wb(1'b1, IX_HSET, 16'h0464);
    repeat (3) @(posedge sys_clk_in);
    chk(home_done_out, 1'b1);
    chk(home_return_out, 1'b0);
    print_verdict();
  end
endmodule
